/* File: inc/sfc_consts.vh */
// Constants for the serial flash command and status block
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// ****************************************
// Opcodes
// ****************************************
`define SFC_OP_WRITE_LATCH_SET   8'h06
`define SFC_OP_WRITE_LATCH_CLEAR 8'h04
`define SFC_OP_STATE_READ        8'h05
`define SFC_OP_STATE_WRITE       8'h01
`define SFC_OP_SIGNATURE         8'hAB
`define SFC_OP_MAKER_PART        8'h90
`define SFC_OP_SECTOR_WIPE       8'h20
`define SFC_OP_BLOCK_WIPE_A      8'h52
`define SFC_OP_BLOCK_WIPE_B      8'hD8
`define SFC_OP_CHIP_WIPE_A       8'h60
`define SFC_OP_CHIP_WIPE_B       8'hC7
`define SFC_OP_PAGE_WRITE        8'h02
`define SFC_OP_DEEP_SLEEP        8'hB9

// ****************************************
// Status field positions
// ****************************************
`define SFC_ST_BUSY      0
`define SFC_ST_LATCH     1
`define SFC_ST_PROT_LO   2
`define SFC_ST_PROT_HI   3
`define SFC_ST_LOCK      7
`define SFC_ST_WR_MASK   8'h8C

// ****************************************
// Timing in microseconds and cycles at 50 MHz
// ****************************************
`define SFC_CLK_MHZ      50
`define SFC_T_STATE_US   10
`define SFC_T_PAGE_US    20
`define SFC_T_SECTOR_US  60
`define SFC_T_BLOCK_US   100
`define SFC_T_CHIP_US    200
`define SFC_CYC(us)      ((us) * `SFC_CLK_MHZ)

`endif

/* File: verif/sfc_core_checker.sv */
// Port checker for the serial flash command block
`timescale 1ns/1ps
module sfc_core_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        sel_b,
  input wire        sdo_oe_r,
  input wire        busy_flag_r,
  input wire        write_latch_r,
  input wire  [1:0] protect_level_r,
  input wire        state_write_lock_r,
  input wire        page_go_r,
  input wire        erase_go_r,
  input wire  [1:0] erase_kind_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_page_pulse: assert property (page_go_r |=> !page_go_r)
    else $error("page go pulse too long");
  a_go_latch: assert property ((page_go_r || erase_go_r) |-> write_latch_r)
    else $error("write accepted without latch");
  a_go_idle: assert property ((page_go_r || erase_go_r) |-> !busy_flag_r)
    else $error("write accepted while busy");
  a_go_busy: assert property ((page_go_r || erase_go_r) |-> ##[1:4] busy_flag_r)
    else $error("busy not raised after write");
  a_chip_free: assert property ((erase_go_r && erase_kind_r == 2'd2) |-> protect_level_r == 2'd0)
    else $error("chip wipe under protection");
  a_go_release: assert property ((page_go_r || erase_go_r) |-> sel_b)
    else $error("write started while selected");
  a_prot_cycle: assert property ($changed({state_write_lock_r, protect_level_r}) |->
    ($past(busy_flag_r) || $past(busy_flag_r, 2)))
    else $error("protect bits changed outside write cycle");
  a_latch_sel: assert property ($rose(write_latch_r) |-> sel_b)
    else $error("latch set while selected");
  a_busy_end: assert property ($fell(busy_flag_r) |-> ##[0:3] !write_latch_r)
    else $error("latch not cleared after cycle");
  a_oe_idle: assert property (sel_b [*8] |=> !sdo_oe_r)
    else $error("output driven while deselected");
endmodule
bind sfc_core sfc_core_checker u_chk (.clk(clk), .rst_b(rst_b), .sel_b(sel_b), .sdo_oe_r(sdo_oe_r),
  .busy_flag_r(busy_flag_r), .write_latch_r(write_latch_r), .protect_level_r(protect_level_r),
  .state_write_lock_r(state_write_lock_r), .page_go_r(page_go_r), .erase_go_r(erase_go_r),
  .erase_kind_r(erase_kind_r));

/* File: verif/sfc_core_tb_top.sv */
// Testbench for the serial flash command block
`timescale 1ns/1ps
module sfc_core_tb_top;
  localparam [7:0] MAKER = 8'h5A; // Arbitrary
  localparam [7:0] PART  = 8'hC3; // Arbitrary
  reg         clk, rst_b, guard_b;
  wire        sel_b, sclk, sdi, sdo_r, sdo_oe_r, sleep_r, busy_flag_r, write_latch_r;
  wire        state_write_lock_r, page_go_r, erase_go_r;
  wire  [1:0] protect_level_r, erase_kind_r;
  wire [23:0] op_addr_r;
  integer     err_count = 0, checks_done = 0, n_go = 0, n_pg = 0, i, nb;
  reg   [7:0] q, r1, r2, op;
  reg  [47:0] ops   = 48'h2052_D860_C702;
  reg  [11:0] kinds = 12'h168;
  sfc_core #(.MAKER_ID(MAKER), .PART_ID(PART), .T_STATE(300), .T_PAGE(200), .T_SECTOR(200),
    .T_BLOCK(200), .T_CHIP(200)) u_dut (.clk(clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk),
    .sdi(sdi), .guard_b(guard_b), .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r), .sleep_r(sleep_r),
    .busy_flag_r(busy_flag_r), .write_latch_r(write_latch_r), .protect_level_r(protect_level_r),
    .state_write_lock_r(state_write_lock_r), .page_go_r(page_go_r), .erase_go_r(erase_go_r),
    .erase_kind_r(erase_kind_r), .op_addr_r(op_addr_r));
  sfc_host u_host (.clk(clk), .sel_b(sel_b), .sclk(sclk), .sdi(sdi), .sdo(sdo_r), .sdo_oe(sdo_oe_r));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (page_go_r || erase_go_r) n_go <= n_go + 1;
    if (page_go_r) n_pg <= n_pg + 1;
  end
  task chk(input [8*12:1] nm, input [23:0] e, input [23:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Sends n bytes of w, reads rd bytes into adds xb stray bits
  task cmd(input [39:0] w, input integer n, input integer rd, input integer xb);
    integer k;
    begin
      u_host.open_frame;
      for (k = n - 1; k >= 0; k = k - 1) u_host.shift(w[8*k +: 8], 8, q);
      for (k = 0; k < rd; k = k + 1) begin
        u_host.shift(8'h00, 8, q);
        r1 = r2;
        r2 = q;
      end
      if (xb > 0) u_host.shift(8'hA5, xb, q);
      u_host.close_frame;
    end
  endtask
  task idle;
    integer t;
    begin
      t  = 0;
      r2 = 8'h01;
      while (r2[0] !== 1'b0 && t < 40) begin
        cmd(40'h05, 1, 1, 0);
        t = t + 1;
      end
      if (t >= 40) chk("idle wait", 0, 1);
    end
  endtask
  task test_done;
    begin
      if (err_count == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count = err_count + 1;
    test_done;
  end
  initial begin
    rst_b   <= 1'b0;
    guard_b <= 1'b1;
    repeat (6) @(posedge clk);
    rst_b   <= 1'b1;
    repeat (4) @(posedge clk);
    idle;
    chk("reset st", 8'h00, r2);
    cmd(40'h06, 1, 0, 0);
    idle;
    chk("latch set", 8'h02, r2);
    cmd(40'h04, 1, 0, 0);
    idle;
    chk("latch clr", 8'h00, r2);
    cmd(40'h018C, 2, 0, 0);
    idle;
    chk("no latch", 8'h00, r2);
    cmd(40'h06, 1, 0, 0);
    cmd(40'h018C, 2, 0, 3);
    idle;
    chk("partial", 8'h02, r2);
    cmd(40'h06, 1, 0, 0);
    cmd(40'h01FC, 2, 0, 0);
    cmd(40'h05, 1, 2, 0);
    chk("busy rd1", 8'h03, r1);
    chk("busy rd2", 8'h03, r2);
    idle;
    chk("st write", 8'h8C, r2);
    guard_b <= 1'b0;
    cmd(40'h06, 1, 0, 0);
    cmd(40'h0100, 2, 0, 0);
    idle;
    chk("guarded", 8'h8C, r2 & 8'hFD);
    guard_b <= 1'b1;
    cmd(40'h06, 1, 0, 0);
    cmd(40'h0104, 2, 0, 0);
    idle;
    chk("unguard", 8'h04, r2);
    cmd(40'h06, 1, 0, 0);
    cmd(40'h2003_0000, 4, 0, 0);
    idle;
    chk("prot blk", 0, n_go);
    cmd(40'h06, 1, 0, 0);
    cmd(40'h60, 1, 0, 0);
    idle;
    chk("chip prot", 0, n_go);
    cmd(40'h06, 1, 0, 0);
    cmd(40'h0100, 2, 0, 0);
    idle;
    for (i = 0; i < 6; i = i + 1) begin
      op = ops[47-8*i -: 8];
      nb = (op == 8'h60 || op == 8'hC7) ? 1 : 4;
      cmd(40'h06, 1, 0, 0);
      cmd((nb == 1) ? {32'h0, op} : {8'h00, op, 24'h01_2340}, nb, 0, 0);
      idle;
      chk("go count", i + 1, n_go);
      if (i < 5) chk("go kind", kinds[11-2*i -: 2], erase_kind_r);
      if (nb == 4) chk("go addr", 24'h01_2340, op_addr_r);
      chk("latch done", 8'h00, r2);
    end
    chk("page count", 1, n_pg);
    cmd(40'hFF, 1, 2, 0);
    chk("unknown oe", 0, u_host.oe_seen);
    cmd(40'h9000_0000, 4, 2, 0);
    chk("id maker1", MAKER, r1);
    chk("id part2", PART, r2);
    cmd(40'h9000_0001, 4, 2, 0);
    chk("id part1", PART, r1);
    chk("id maker2", MAKER, r2);
    cmd(40'hB9, 1, 0, 0);
    chk("sleep", 1, sleep_r);
    cmd(40'h06, 1, 0, 0);
    chk("sleep wr", 0, write_latch_r);
    cmd(40'hAB00_0000, 4, 1, 0);
    chk("wake id", PART, r2);
    chk("wake", 0, sleep_r);
    cmd(40'hB9, 1, 0, 0);
    chk("sleep again", 1, sleep_r);
    cmd(40'hAB, 1, 0, 0);
    chk("wake alone", 0, sleep_r);
    cmd(40'h06, 1, 0, 0);
    chk("wake latch", 1, write_latch_r);
    test_done;
  end
endmodule

/* File: verif/sfc_host.sv */
// Serial host model driving select, clock and data in
`timescale 1ns/1ps
module sfc_host (
  input  wire clk,
  output reg  sel_b,
  output reg  sclk,
  output reg  sdi,
  input  wire sdo,
  input  wire sdo_oe
);
  reg  last    = 1'b0;
  reg  oe_seen = 1'b0;
  // Released line shows the inverse of its last driven level
  wire lvl     = sdo_oe ? sdo : ~last;
  initial begin
    sel_b = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  always @(posedge clk) begin
    if (sdo_oe) last <= sdo;
  end
  task tick(input integer n);
    repeat (n) begin
      @(posedge clk);
      if (sdo_oe) oe_seen = 1'b1;
    end
  endtask
  task open_frame;
    begin
      tick(1);
      sel_b  <= 1'b0;
      oe_seen = 1'b0;
      tick(4);
    end
  endtask
  task close_frame;
    begin
      tick(4);
      sel_b <= 1'b1;
      tick(24);
    end
  endtask
  // MSB first; clock stands low outside frames
  task shift(input [7:0] d, input integer n, output [7:0] q);
    integer b;
    begin
      for (b = 7; b > 7 - n; b = b - 1) begin
        sdi  <= d[b];
        tick(4);
        sclk <= 1'b1;
        tick(4);
        q     = {q[6:0], lvl};
        sclk <= 1'b0;
      end
    end
  endtask
endmodule

/* File: verilog/sfc_core.v */
// Serial flash command decoder and status register
`timescale 1ns/1ps
`include "sfc_consts.vh"

module sfc_core #(
  parameter [7:0] MAKER_ID  = 8'hA5,   // Arbitrary
  parameter [7:0] PART_ID   = 8'h3C,   // Arbitrary
  parameter       T_STATE   = `SFC_CYC(`SFC_T_STATE_US),
  parameter       T_PAGE    = `SFC_CYC(`SFC_T_PAGE_US),
  parameter       T_SECTOR  = `SFC_CYC(`SFC_T_SECTOR_US),
  parameter       T_BLOCK   = `SFC_CYC(`SFC_T_BLOCK_US),
  parameter       T_CHIP    = `SFC_CYC(`SFC_T_CHIP_US),
  parameter [7:0] STATE_INI = 8'h00
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       sel_b,
  input  wire       sclk,
  input  wire       sdi,
  input  wire       guard_b,
  output reg        sdo_r,
  output reg        sdo_oe_r,
  output reg        sleep_r,
  output reg        busy_flag_r,
  output reg        write_latch_r,
  output reg  [1:0] protect_level_r,
  output reg        state_write_lock_r,
  output reg        page_go_r,
  output reg        erase_go_r,
  output reg  [1:0] erase_kind_r,
  output reg [23:0] op_addr_r
);

  localparam TW = 24;
  localparam K_NONE = 3'd0, K_STATE = 3'd1, K_PAGE = 3'd2;
  localparam K_SECT = 3'd3, K_BLOCK = 3'd4, K_CHIP = 3'd5;

  // Command phases
  localparam S_OP   = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_OUT  = 3'd3;
  localparam S_IDLE = 3'd4;
  localparam S_DONE = 3'd5;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] sel_s_r, sclk_s_r, sdi_s_r, grd_s_r;
  reg       sel_d_r, sclk_d_r;

  always @(posedge clk) begin
    if (!rst_b) begin
      sel_s_r  <= 2'b11;
      sclk_s_r <= 2'b00;
      sdi_s_r  <= 2'b00;
      grd_s_r  <= 2'b11;
      sel_d_r  <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      sel_s_r  <= {sel_s_r[0], sel_b};
      sclk_s_r <= {sclk_s_r[0], sclk};
      sdi_s_r  <= {sdi_s_r[0], sdi};
      grd_s_r  <= {grd_s_r[0], guard_b};
      sel_d_r  <= sel_s_r[1];
      sclk_d_r <= sclk_s_r[1];
    end
  end

  wire sel_now  = ~sel_s_r[1];
  wire sel_fall = sel_d_r & ~sel_s_r[1];
  wire sel_rise = ~sel_d_r & sel_s_r[1];
  wire sck_rise = sel_now & ~sclk_d_r & sclk_s_r[1];
  wire sck_fall = sel_now & sclk_d_r & ~sclk_s_r[1];

  // ****************************************
  // Helpers
  // ****************************************
  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = (op == `SFC_OP_STATE_WRITE) || (op == `SFC_OP_PAGE_WRITE) ||
                    (op == `SFC_OP_SECTOR_WIPE) || (op == `SFC_OP_BLOCK_WIPE_A) ||
                    (op == `SFC_OP_BLOCK_WIPE_B) || (op == `SFC_OP_CHIP_WIPE_A) ||
                    (op == `SFC_OP_CHIP_WIPE_B);
    end
  endfunction

  // Block number 0..3 of a 256 KiB array split into 64 KiB blocks
  function addr_protected;
    input [1:0]  lvl;
    input [23:0] a;
    begin
      case (lvl)
        2'd0:    addr_protected = 1'b0;
        2'd1:    addr_protected = (a[17:16] == 2'd3);
        2'd2:    addr_protected = a[17];
        default: addr_protected = 1'b1;
      endcase
    end
  endfunction

  // ****************************************
  // Shift engine
  // ****************************************
  reg  [2:0]  st_r;
  reg  [2:0]  bit_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  op_r;
  reg  [1:0]  nbyte_r;
  reg  [23:0] addr_r;
  reg  [7:0]  data_r;
  reg  [7:0]  out_r;
  reg         tail_ok_r;
  reg         out_flip_r;
  wire [7:0]  sh_nxt = {sh_r[6:0], sdi_s_r[1]};
  wire        tmr_busy;
  wire        tmr_done;
  reg         tmr_go_r;
  reg  [2:0]  kind_r;
  reg  [TW-1:0] tmr_len_r;
  reg  [7:0]  pend_data_r;

  wire [7:0] status = {state_write_lock_r, 3'b000, protect_level_r,
                       write_latch_r, busy_flag_r};

  always @(posedge clk) begin
    if (!rst_b) begin
      st_r       <= S_OP;
      bit_r      <= 3'd0;
      sh_r       <= 8'h00;
      op_r       <= 8'h00;
      nbyte_r    <= 2'd0;
      addr_r     <= 24'h00_0000;
      data_r     <= 8'h00;
      out_r      <= 8'h00;
      tail_ok_r  <= 1'b0;
      out_flip_r <= 1'b0;
      sdo_r      <= 1'b0;
      sdo_oe_r   <= 1'b0;
    end else if (sel_fall || !sel_now) begin
      st_r      <= S_OP;
      bit_r     <= 3'd0;
      nbyte_r   <= 2'd0;
      tail_ok_r <= 1'b0;
      sdo_oe_r  <= 1'b0;
    end else begin
      if (sck_rise) begin
        bit_r <= bit_r + 3'd1;
        sh_r  <= sh_nxt;
        if (bit_r != 3'd7) tail_ok_r <= 1'b0;
      end
      if (sck_rise && bit_r == 3'd7) begin
        case (st_r)
          S_OP: begin
            op_r      <= sh_nxt;
            tail_ok_r <= 1'b1;
            nbyte_r   <= 2'd0;
            if (sleep_r && sh_nxt != `SFC_OP_SIGNATURE)
              st_r <= S_IDLE;
            else if (sh_nxt == `SFC_OP_STATE_READ) begin
              st_r  <= S_OUT;
              out_r <= status;
            end else if (sh_nxt == `SFC_OP_STATE_WRITE)
              st_r <= S_DATA;
            else if (sh_nxt == `SFC_OP_WRITE_LATCH_SET || sh_nxt == `SFC_OP_WRITE_LATCH_CLEAR ||
                     sh_nxt == `SFC_OP_DEEP_SLEEP || sh_nxt == `SFC_OP_CHIP_WIPE_A ||
                     sh_nxt == `SFC_OP_CHIP_WIPE_B)
              st_r <= S_DONE;
            else if (sh_nxt == `SFC_OP_SIGNATURE || sh_nxt == `SFC_OP_MAKER_PART ||
                     sh_nxt == `SFC_OP_PAGE_WRITE || sh_nxt == `SFC_OP_SECTOR_WIPE ||
                     sh_nxt == `SFC_OP_BLOCK_WIPE_A || sh_nxt == `SFC_OP_BLOCK_WIPE_B)
              st_r <= S_ADDR;
            else
              st_r <= S_IDLE;
          end
          S_ADDR: begin
            addr_r    <= {addr_r[15:0], sh_nxt};
            nbyte_r   <= nbyte_r + 2'd1;
            tail_ok_r <= (nbyte_r == 2'd2);
            if (nbyte_r == 2'd2) begin
              if (op_r == `SFC_OP_SIGNATURE) begin
                st_r  <= S_OUT;
                out_r <= PART_ID;
              end else if (op_r == `SFC_OP_MAKER_PART) begin
                st_r       <= S_OUT;
                out_flip_r <= sh_nxt[0];
                out_r      <= sh_nxt[0] ? PART_ID : MAKER_ID;
              end else
                st_r <= S_DONE;
            end
          end
          S_DATA: begin
            data_r    <= sh_nxt;
            tail_ok_r <= 1'b1;
            st_r      <= S_DONE;
          end
          S_DONE: begin
            tail_ok_r <= 1'b0;
            st_r      <= S_IDLE;
          end
          S_OUT: begin
            if (op_r == `SFC_OP_STATE_READ)
              out_r <= status;
            else if (op_r == `SFC_OP_MAKER_PART) begin
              out_flip_r <= ~out_flip_r;
              out_r      <= out_flip_r ? MAKER_ID : PART_ID;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
      // Output shifts on falling edges only while reading
      if (sck_fall && st_r == S_OUT) begin
        sdo_oe_r <= 1'b1;
        sdo_r    <= out_r[~bit_r];
      end else if (st_r == S_IDLE) begin
        sdo_oe_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Execution at select release; write-cycle end at timer done, signature wake also at its third address byte
  // ****************************************
  wire hw_guard = state_write_lock_r & ~grd_s_r[1];
  wire end_ok   = sel_rise && tail_ok_r && bit_r == 3'd0 && st_r == S_DONE;
  wire wipe_hit = addr_protected(protect_level_r, addr_r);

  always @(posedge clk) begin
    if (!rst_b) begin
      sleep_r            <= 1'b0;
      write_latch_r      <= 1'b0;
      busy_flag_r        <= 1'b0;
      protect_level_r    <= STATE_INI[`SFC_ST_PROT_HI:`SFC_ST_PROT_LO];
      state_write_lock_r <= STATE_INI[`SFC_ST_LOCK];
      page_go_r          <= 1'b0;
      erase_go_r         <= 1'b0;
      erase_kind_r       <= 2'd0;
      op_addr_r          <= 24'h00_0000;
      tmr_go_r           <= 1'b0;
      tmr_len_r          <= {TW{1'b0}};
      kind_r             <= K_NONE;
      pend_data_r        <= 8'h00;
    end else begin
      page_go_r   <= 1'b0;
      erase_go_r  <= 1'b0;
      tmr_go_r    <= 1'b0;
      busy_flag_r <= tmr_busy | tmr_go_r;
      if (sck_rise && bit_r == 3'd7 && st_r == S_ADDR && nbyte_r == 2'd2 &&
          op_r == `SFC_OP_SIGNATURE)
        sleep_r <= 1'b0;
      // Signature opcode alone, closed on its byte boundary, also wakes
      if (sel_rise && tail_ok_r && bit_r == 3'd0 && st_r == S_ADDR && op_r == `SFC_OP_SIGNATURE)
        sleep_r <= 1'b0;
      if (tmr_done) begin
        write_latch_r <= 1'b0;
        if (kind_r == K_STATE) begin
          state_write_lock_r <= pend_data_r[`SFC_ST_LOCK];
          protect_level_r    <= pend_data_r[`SFC_ST_PROT_HI:`SFC_ST_PROT_LO];
        end
        kind_r <= K_NONE;
      end
      if (end_ok && !tmr_busy && !tmr_go_r) begin
        op_addr_r <= addr_r;
        if (op_r == `SFC_OP_WRITE_LATCH_SET)
          write_latch_r <= 1'b1;
        else if (op_r == `SFC_OP_WRITE_LATCH_CLEAR)
          write_latch_r <= 1'b0;
        else if (op_r == `SFC_OP_DEEP_SLEEP)
          sleep_r <= 1'b1;
        else if (is_write_op(op_r) && write_latch_r && !tmr_done) begin
          if (op_r == `SFC_OP_STATE_WRITE) begin
            if (!hw_guard) begin
              tmr_go_r    <= 1'b1;
              tmr_len_r   <= T_STATE[TW-1:0];
              kind_r      <= K_STATE;
              pend_data_r <= data_r & `SFC_ST_WR_MASK;
            end
          end else if (op_r == `SFC_OP_CHIP_WIPE_A || op_r == `SFC_OP_CHIP_WIPE_B) begin
            if (protect_level_r == 2'd0) begin
              tmr_go_r     <= 1'b1;
              tmr_len_r    <= T_CHIP[TW-1:0];
              kind_r       <= K_CHIP;
              erase_go_r   <= 1'b1;
              erase_kind_r <= 2'd2;
            end
          end else if (!wipe_hit) begin
            tmr_go_r <= 1'b1;
            if (op_r == `SFC_OP_PAGE_WRITE) begin
              tmr_len_r <= T_PAGE[TW-1:0];
              kind_r    <= K_PAGE;
              page_go_r <= 1'b1;
            end else if (op_r == `SFC_OP_SECTOR_WIPE) begin
              tmr_len_r    <= T_SECTOR[TW-1:0];
              kind_r       <= K_SECT;
              erase_go_r   <= 1'b1;
              erase_kind_r <= 2'd0;
            end else begin
              tmr_len_r    <= T_BLOCK[TW-1:0];
              kind_r       <= K_BLOCK;
              erase_go_r   <= 1'b1;
              erase_kind_r <= 2'd1;
            end
          end
        end
      end
    end
  end

  sfc_timer #(
    .W (TW)
  ) u_timer (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (tmr_go_r),
    .cycles (tmr_len_r),
    .busy_r (tmr_busy),
    .done_r (tmr_done)
  );

endmodule

/* File: verilog/sfc_timer.v */
// Busy timer for self-timed write cycles
`timescale 1ns/1ps

module sfc_timer #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         start,
  input  wire [W-1:0] cycles,
  output reg          busy_r,
  output reg          done_r
);

  reg [W-1:0] cnt_r;

  // ****************************************
  // Countdown
  // ****************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_r  <= {W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        cnt_r  <= cycles;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
